// ==== src/smart_log_params.svh ====
// Constants for the reliability command and self-test log block
`ifndef SMART_LOG_PARAMS_SVH
`define SMART_LOG_PARAMS_SVH
`define CLK_HZ 40000000
`define HOUR_S 3600
`define OFF_HOURS 5'h18
`define R_FEAT 8'h00
`define R_SCNT 8'h04
`define R_SNUM 8'h08
`define R_CYLO 8'h0C
`define R_CYHI 8'h10
`define R_CMD 8'h14
`define R_STAT 8'h18
`define R_LADR 8'h1C
`define R_LDAT 8'h20
`define CMD_SMART 8'hB0
`define CYL_KEY 16'hC24F
`define CYL_BAD 16'h2CF4
`define F_WLOG 8'hD6
`define F_ENA 8'hD8
`define F_DIS 8'hD9
`define F_STAT 8'hDA
`define F_AUTO 8'hDB
`define SC_ON 8'hF8
`define SC_OFF 8'h00
`define LOG_REV 16'h0001
`define N_DESC 5'h15
`define DESC_B 10'h018
`define DESC_USED 5'h09
`define DESC_0 10'h002
`define DESC_END 10'h1FA
`define IDX_B 10'h1FC
`define SUM_B 10'h1FF
`define SEC_LAST 9'h1FF
`endif

// ==== src/smart_log_pkg.sv ====
// Types shared by the self-test log command block
package smart_log_pkg;
  typedef enum logic [1:0] {IDLE = 2'b00, EXEC = 2'b01, DATA = 2'b10} state_e;
  // Byte order of a descriptor: snum is byte 0, lba bytes 5..8
  typedef struct packed {
    logic [31:0] lba;
    logic [7:0] chk;
    logic [15:0] hrs;
    logic [7:0] stat;
    logic [7:0] snum;
  } desc_s;
endpackage : smart_log_pkg

// ==== src/smart_selftest_log.sv ====
// Reliability subcommand interpreter and self-test log sector
`timescale 1ns/100ps
`default_nettype none
`include "smart_log_params.svh"
// Operation
// (RULE1) Log bytes 0-1 hold revision 0001h.
// (RULE2) 21 circular descriptors of 24 bytes from offset 2; 22nd reuses slot one.
// (RULE3) Unwritten descriptors read as zero.
// (RULE4) Descriptor: sector number, status, hours, checkpoint, failing address, vendor.
// (RULE5) Sector number taken at issue; status and checkpoint at completion.
// (RULE6) Timestamp is powered-on hours at completion.
// (RULE7) Failing address is first uncorrectable sector; else undefined.
// (RULE8) Index at 508 names latest entry, zero when empty, wraps to one.
// (RULE9) Byte 511 makes the sector sum to zero.
// (RULE10) Log write takes 512 bytes and ends with sector count 00h.
// (RULE11) Enable: busy, monitoring on, busy off, then interrupt.
// (RULE12) No parameters tracked while monitoring is off.
// (RULE13) Enable state kept in non-volatile storage.
// (RULE14) Repeated enable leaves collected parameters unchanged.
// (RULE15) Disable: busy, stop monitoring and timers, busy off, interrupt.
// (RULE16) While disabled, all but enable abort with aborted-command error.
// (RULE17) Return status writes C24Fh when healthy, 2CF4h when failure predicted.
// (RULE18) Return status saves parameters to non-volatile memory and evaluates.
// (RULE19) Auto off-line with count zero disables the feature.
// (RULE20) Count F8h enables auto off-line; other values vendor-defined.
// (RULE21) Auto off-line collection runs every 24 powered-on hours.
// (RULE22) Saves on power or recovery events continue regardless.
// (RULE23) Host loads parameters before writing the command code.
module smart_selftest_log #(
  parameter logic [39:0] HOUR_CYCLES = 40'(`HOUR_S) * 40'(`CLK_HZ)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic stStart,
  input wire logic stDone,
  input wire logic [7:0] stStatus,
  input wire logic [7:0] stCheckpoint,
  input wire logic [31:0] stLba,
  input wire logic failPredict,
  input wire logic pwrEvent,
  input wire logic nvSmartIn,
  output logic busy,
  output logic intrq,
  output logic monitorEn,
  output logic nvSave,
  output logic offlineRun
);
  smart_log_pkg::state_e state;
  smart_log_pkg::desc_s logMem [21];
  logic [7:0] feat, scnt, snum, cylLo, cylHi;
  logic abortQ, err, loaded, autoOff;
  logic [8:0] ptr;
  logic [7:0] wbuf [512];
  logic [9:0] logAddr;
  logic [4:0] index;
  logic [7:0] sumEnt, pendSnum;
  logic [39:0] cycCnt;
  logic [15:0] powerHours;
  logic hourTick;
  logic [4:0] offCnt;
  logic fp1, fp2, fp3, fpStable;
  logic pw1, pw2, pw3, pwStable;
  logic [31:0] rdata;

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire rd = req & ~wb_we_i;
  wire idle = state == smart_log_pkg::IDLE;
  wire cmdGo = wr && wb_adr_i == `R_CMD && idle;
  wire hostWr = wr && idle;
  wire exec = state == smart_log_pkg::EXEC;
  wire good = exec && !abortQ;
  wire lastByte = state == smart_log_pkg::DATA && wr && wb_adr_i == `R_LDAT
                  && ptr == `SEC_LAST;
  wire statRd = rd && wb_adr_i == `R_STAT;
  wire known = feat == `F_WLOG || feat == `F_ENA || feat == `F_DIS
               || feat == `F_STAT || feat == `F_AUTO;
  wire cmdOk = wb_dat_i[7:0] == `CMD_SMART && {cylHi, cylLo} == `CYL_KEY
               && known && (monitorEn || feat == `F_ENA);
  wire [4:0] slot = (index == `N_DESC) ? 5'h00 : index;

  function automatic logic [7:0] dsum(input smart_log_pkg::desc_s d);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < int'(`DESC_USED); i++) begin
      s = 8'(s + d[i*8 +: 8]);
    end
    return s;
  endfunction : dsum

  wire [7:0] fixedSum = 8'(`LOG_REV >> 8) + 8'(`LOG_REV);
  wire [7:0] chkByte = 8'(8'h00 - 8'(sumEnt + fixedSum + {3'b000, index})); // [RULE9]

  function automatic logic [7:0] logByte(input logic [9:0] a);
    logic [9:0] off;
    logic [4:0] e, f;
    logic [71:0] d;
    off = 10'(a - `DESC_0);
    e = 5'(off / `DESC_B);
    f = 5'(off % `DESC_B);
    d = logMem[e];
    logByte = 8'h00;
    if (a < `DESC_0) begin
      logByte = a[0] ? 8'(`LOG_REV >> 8) : 8'(`LOG_REV); // [RULE1]
    end else if (a < `DESC_END) begin
      if (f < `DESC_USED) begin
        logByte = d[f*8 +: 8]; // [RULE2] [RULE4]
      end
    end else if (a == `IDX_B) begin
      logByte = {3'b000, index}; // [RULE8]
    end else if (a == `SUM_B) begin
      logByte = chkByte;
    end
  endfunction : logByte

  // Command sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= smart_log_pkg::IDLE;
      abortQ <= 1'b0;
      busy <= 1'b0;
      ptr <= 9'h000;
    end else begin
      case (state)
        smart_log_pkg::IDLE: begin
          if (cmdGo) begin
            state <= smart_log_pkg::EXEC;
            abortQ <= !cmdOk; // [RULE16]
            busy <= 1'b1; // [RULE11] [RULE15] [RULE18]
          end
        end
        smart_log_pkg::EXEC: begin
          busy <= 1'b0;
          ptr <= 9'h000;
          if (good && feat == `F_WLOG) begin
            state <= smart_log_pkg::DATA; // [RULE10]
          end else begin
            state <= smart_log_pkg::IDLE;
          end
        end
        smart_log_pkg::DATA: begin
          if (wr && wb_adr_i == `R_LDAT) begin
            ptr <= 9'(ptr + 9'h001);
            if (ptr == `SEC_LAST) begin
              state <= smart_log_pkg::IDLE;
            end
          end
        end
        default: state <= smart_log_pkg::IDLE;
      endcase
    end
  end

  // Interrupt and error: a completion in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      intrq <= 1'b0;
      err <= 1'b0;
    end else begin
      if ((exec && !(good && feat == `F_WLOG)) || lastByte) begin
        intrq <= 1'b1; // [RULE11] [RULE15]
      end else if (cmdGo || statRd) begin
        intrq <= 1'b0;
      end
      if (exec && abortQ) begin
        err <= 1'b1; // [RULE16]
      end else if (cmdGo) begin
        err <= 1'b0;
      end
    end
  end

  // Task file; host writes ignored while a command runs
  always_ff @(posedge clk) begin
    if (rst) begin
      feat <= 8'h00;
      scnt <= 8'h00;
      snum <= 8'h00;
      cylLo <= 8'h00;
      cylHi <= 8'h00;
    end else begin
      if (hostWr && wb_adr_i == `R_FEAT) feat <= wb_dat_i[7:0];
      if (hostWr && wb_adr_i == `R_SCNT) scnt <= wb_dat_i[7:0];
      if (hostWr && wb_adr_i == `R_SNUM) snum <= wb_dat_i[7:0];
      if (hostWr && wb_adr_i == `R_CYLO) cylLo <= wb_dat_i[7:0];
      if (hostWr && wb_adr_i == `R_CYHI) cylHi <= wb_dat_i[7:0];
      if (lastByte) scnt <= 8'h00; // [RULE10]
      if (good && feat == `F_STAT) begin
        {cylHi, cylLo} <= fpStable ? `CYL_BAD : `CYL_KEY; // [RULE17] [RULE18]
      end
    end
  end

  // Host log sector data; the first byte lands at slot zero
  always_ff @(posedge clk) begin
    if (state == smart_log_pkg::DATA && wr && wb_adr_i == `R_LDAT) begin
      wbuf[ptr] <= wb_dat_i[7:0]; // [RULE10]
    end
  end

  // Monitoring state; the level is restored from storage after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      monitorEn <= 1'b0;
      loaded <= 1'b0;
      autoOff <= 1'b0;
    end else begin
      if (!loaded) begin
        loaded <= 1'b1;
        monitorEn <= nvSmartIn; // [RULE13]
      end else if (good && feat == `F_ENA) begin
        monitorEn <= 1'b1; // [RULE11] [RULE14]
      end else if (good && feat == `F_DIS) begin
        monitorEn <= 1'b0; // [RULE15]
      end
      if (good && feat == `F_AUTO && scnt == `SC_OFF) begin
        autoOff <= 1'b0; // [RULE19]
      end else if (good && feat == `F_AUTO && scnt == `SC_ON) begin
        autoOff <= 1'b1; // [RULE20]
      end
    end
  end

  // Pin synchronisers: a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      {fp1, fp2, fp3, fpStable} <= 4'h0;
      {pw1, pw2, pw3, pwStable} <= 4'h0;
    end else begin
      fp1 <= failPredict;
      fp2 <= fp1;
      fp3 <= fp2;
      if (fp2 == fp3) fpStable <= fp3;
      pw1 <= pwrEvent;
      pw2 <= pw1;
      pw3 <= pw2;
      if (pw2 == pw3) pwStable <= pw3;
    end
  end

  // Save strobe: status request or power/recovery event
  always_ff @(posedge clk) begin
    if (rst) begin
      nvSave <= 1'b0;
    end else begin
      nvSave <= (good && feat == `F_STAT) // [RULE18]
                || (pw2 == pw3 && pw3 && !pwStable); // [RULE22]
    end
  end

  // Powered-on hours since reset
  always_ff @(posedge clk) begin
    if (rst) begin
      cycCnt <= 40'h00_0000_0000;
      hourTick <= 1'b0;
      powerHours <= 16'h0000;
    end else begin
      hourTick <= 1'b0;
      if (cycCnt == HOUR_CYCLES - 40'h1) begin
        cycCnt <= 40'h00_0000_0000;
        hourTick <= 1'b1;
        powerHours <= 16'(powerHours + 16'h0001);
      end else begin
        cycCnt <= 40'(cycCnt + 40'h1);
      end
    end
  end

  // Off-line timer clears and holds at zero whenever monitoring or auto off-line is off
  always_ff @(posedge clk) begin
    if (rst) begin
      offCnt <= 5'h00;
      offlineRun <= 1'b0;
    end else begin
      offlineRun <= 1'b0;
      if (!(monitorEn && autoOff)) begin
        offCnt <= 5'h00; // [RULE12] [RULE15]
      end else if (hourTick) begin
        if (offCnt == `OFF_HOURS - 5'h01) begin
          offCnt <= 5'h00;
          offlineRun <= 1'b1; // [RULE21]
        end else begin
          offCnt <= 5'(offCnt + 5'h01);
        end
      end
    end
  end

  // Self-test log; the checksum follows a running sum of entries
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < int'(`N_DESC); i++) begin
        logMem[i] <= '0; // [RULE3]
      end
      index <= 5'h00;
      sumEnt <= 8'h00;
      pendSnum <= 8'h00;
    end else begin
      if (stStart) pendSnum <= snum; // [RULE5]
      if (stDone) begin
        logMem[slot] <= '{lba: stLba, chk: stCheckpoint, hrs: powerHours,
                          stat: stStatus, snum: pendSnum}; // [RULE5] [RULE6] [RULE7]
        index <= 5'(slot + 5'h01); // [RULE2] [RULE8]
        sumEnt <= 8'(sumEnt - dsum(logMem[slot])
                  + dsum('{lba: stLba, chk: stCheckpoint, hrs: powerHours,
                           stat: stStatus, snum: pendSnum}));
      end
    end
  end

  // Register bus
  always_comb begin
    rdata = 32'h0000_0000;
    case (wb_adr_i)
      `R_FEAT: rdata[7:0] = feat;
      `R_SCNT: rdata[7:0] = scnt;
      `R_SNUM: rdata[7:0] = snum;
      `R_CYLO: rdata[7:0] = cylLo;
      `R_CYHI: rdata[7:0] = cylHi;
      `R_STAT: rdata[5:0] = {autoOff, monitorEn,
                             state == smart_log_pkg::DATA, err, intrq, busy};
      `R_LADR: rdata[9:0] = logAddr;
      `R_LDAT: rdata[7:0] = logByte(logAddr);
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      logAddr <= 10'h000;
    end else begin
      wb_ack_o <= req;
      if (rd) wb_dat_o <= rdata;
      if (wr && wb_adr_i == `R_LADR) begin
        logAddr <= wb_dat_i[9:0];
      end else if (rd && wb_adr_i == `R_LDAT) begin
        logAddr <= 10'(logAddr + 10'h001);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_ENA_ON: assert property (good && feat == `F_ENA |=> monitorEn) // [RULE11]
    else $error("enable did not turn monitoring on");
  AST_DIS_OFF: assert property (good && feat == `F_DIS |=> !monitorEn) // [RULE15]
    else $error("disable left monitoring on");
  AST_IRQ_AFTER: assert property (exec && !(good && feat == `F_WLOG)
    |=> intrq && !busy) // [RULE11]
    else $error("no interrupt when busy dropped");
  AST_ABORT: assert property (cmdGo && !monitorEn && feat != `F_ENA
    |=> busy ##1 err && intrq) // [RULE16]
    else $error("command not aborted while disabled");
  AST_STAT_CYL: assert property (good && feat == `F_STAT
    |=> {cylHi, cylLo} == ($past(fpStable) ? `CYL_BAD : `CYL_KEY) && nvSave) // [RULE17]
    else $error("status cylinder value wrong");
  AST_IDX_WRAP: assert property (stDone && index == `N_DESC |=> index == 5'h01) // [RULE8]
    else $error("index did not wrap to one");
  AST_IDX_INC: assert property (stDone && index < `N_DESC
    |=> index == 5'($past(index) + 5'h01)) // [RULE8]
    else $error("index did not advance");
  // The pulse is registered, so the enables are those of the cycle before it
  AST_OFF_RUN: assert property (offlineRun |-> $past(monitorEn && autoOff)) // [RULE21]
    else $error("off-line run without enable");
  AST_WLOG_DONE: assert property (lastByte |=> scnt == 8'h00 && intrq && idle) // [RULE10]
    else $error("log write did not complete");
  AST_AUTO_OFF: assert property (good && feat == `F_AUTO && scnt == `SC_OFF
    |=> !autoOff ##1 !offlineRun) // [RULE19]
    else $error("auto off-line not disabled");
  COV_ENABLE: cover property (good && feat == `F_ENA ##1 intrq);
  COV_WRAP: cover property (stDone && index == `N_DESC);
  COV_ABORT: cover property (exec && abortQ);
  COV_WLOG: cover property (lastByte);
endmodule : smart_selftest_log
`default_nettype wire

// ==== verification/smart_host_model.sv ====
// Host model: Wishbone master that loads the task file and issues commands
`timescale 1ns/100ps
`default_nettype none
`include "smart_log_params.svh"
module smart_host_model (
  input wire logic clk,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [7:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  int hangs = 0;
  initial begin
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
  end
  // Request held until ack is sampled at a rising edge, then released
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 64);
    if (n >= 64) hangs++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
    // Released lines flip so a stale address or datum cannot pass unseen
    wb_adr_i <= ~adr;
    wb_dat_i <= ~dat;
  endtask : xfer
  task automatic wr(input logic [7:0] adr, input logic [9:0] dat);
    logic [31:0] unused;
    xfer(1'h1, adr, {22'h0, dat}, unused);
  endtask : wr
  task automatic rd(input logic [7:0] adr, output logic [7:0] dat);
    logic [31:0] word;
    xfer(1'h0, adr, 32'h0, word);
    dat = word[7:0];
  endtask : rd
  // Parameters first; the command code goes last because it starts execution
  task automatic smartCmd(input logic [7:0] feat, input logic [7:0] scnt,
                          input logic [7:0] snum, input logic [15:0] cyl);
    wr(`R_FEAT, {2'h0, feat});
    wr(`R_SCNT, {2'h0, scnt});
    wr(`R_SNUM, {2'h0, snum});
    wr(`R_CYLO, {2'h0, cyl[7:0]});
    wr(`R_CYHI, {2'h0, cyl[15:8]});
    wr(`R_CMD, {2'h0, `CMD_SMART});
  endtask : smartCmd
endmodule : smart_host_model
`default_nettype wire

// ==== verification/smart_selftest_log_commands_tb_top.sv ====
// Self-checking bench for the reliability command and self-test log block
`timescale 1ns/100ps
`default_nettype none
`include "smart_log_params.svh"
module smart_selftest_log_commands_tb_top;
  localparam int HOUR_N = 100;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic busy, intrq, monitorEn, nvSave, offlineRun;
  logic stStart = 1'h0;
  logic stDone = 1'h0;
  logic [7:0] stStatus = 8'h00;
  logic [7:0] stCheckpoint = 8'h00;
  logic [31:0] stLba = 32'h0;
  logic failPredict = 1'h0;
  logic pwrEvent = 1'h0;
  logic nvSmartIn = 1'h0;
  int miscompares = 0;
  int checked = 0;
  // Edges since reset release; an hour is HOUR_N of them
  int upCycles = 0;
  int hrsAt [23];
  always #12.5 clk = ~clk;
  always @(posedge clk) upCycles <= rst ? 0 : upCycles + 1;
  smart_host_model host (.clk(clk), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  smart_selftest_log #(.HOUR_CYCLES(40'(HOUR_N))) dut (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .stStart(stStart), .stDone(stDone), .stStatus(stStatus), .stCheckpoint(stCheckpoint),
    .stLba(stLba), .failPredict(failPredict), .pwrEvent(pwrEvent), .nvSmartIn(nvSmartIn),
    .busy(busy), .intrq(intrq), .monitorEn(monitorEn), .nvSave(nvSave),
    .offlineRun(offlineRun));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    miscompares += host.hangs;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic doReset(input logic nv);
    rst <= 1'h1;
    nvSmartIn <= nv;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
  endtask : doReset
  task automatic cmd(input logic [7:0] feat, input logic [7:0] scnt, output logic [7:0] st);
    host.smartCmd(feat, scnt, 8'h00, `CYL_KEY);
    @(posedge clk);
    host.rd(`R_STAT, st);
  endtask : cmd
  task automatic logByte(input logic [9:0] a, output logic [7:0] b);
    host.wr(`R_LADR, a);
    host.rd(`R_LDAT, b);
  endtask : logByte
  task automatic countPulses(input int cycles, input logic save, output int n);
    n = 0;
    repeat (cycles) begin
      @(posedge clk);
      n += ((save ? nvSave : offlineRun) === 1'h1);
    end
  endtask : countPulses
  task automatic testAbortOff();
    logic [7:0] st;
    cmd(`F_STAT, 8'h00, st);
    check("status while off err", st[2], 1'h1);
    cmd(`F_DIS, 8'h00, st);
    check("disable while off err", st[2], 1'h1);
    check("monitor still off", monitorEn, 1'h0);
  endtask : testAbortOff
  // Second pass repeats enable on an enabled device
  task automatic testOnOff(input logic [7:0] feat, input logic on);
    logic [7:0] st;
    host.smartCmd(feat, 8'h00, 8'h00, `CYL_KEY);
    check("busy raised", busy, 1'h1);
    @(posedge clk);
    check("busy dropped", busy, 1'h0);
    check("intrq raised", intrq, 1'h1);
    check("monitor state", monitorEn, on);
    host.rd(`R_STAT, st);
    check("no error", st[2], 1'h0);
  endtask : testOnOff
  task automatic testStatus();
    logic [7:0] lo, hi;
    for (int f = 0; f < 2; f++) begin
      failPredict <= f[0];
      repeat (6) @(posedge clk);
      host.smartCmd(`F_STAT, 8'h00, 8'h00, `CYL_KEY);
      @(posedge clk);
      check("save on status", nvSave, 1'h1);
      host.rd(`R_CYLO, lo);
      host.rd(`R_CYHI, hi);
      check("cylinder low", lo, f[0] ? 8'hF4 : 8'h4F);
      check("cylinder high", hi, f[0] ? 8'h2C : 8'hC2);
    end
    failPredict <= 1'h0;
  endtask : testStatus
  task automatic selfTest(input logic [7:0] k);
    host.wr(`R_SNUM, {2'h0, k});
    stStart <= 1'h1;
    @(posedge clk);
    stStart <= 1'h0;
    // A later sector number must not leak into the entry
    host.wr(`R_SNUM, 10'h0EE);
    stStatus <= k ^ 8'h40;
    stCheckpoint <= k ^ 8'h80;
    stLba <= {k, 8'h5A, ~k, 8'h3C};
    stDone <= 1'h1;
    @(posedge clk);
    hrsAt[k] = upCycles / HOUR_N;
    stDone <= 1'h0;
    repeat (2) @(posedge clk);
  endtask : selfTest
  // Hours are the powered-on hours seen at the completion edge
  task automatic checkDesc(input int slot, input logic [7:0] k, input logic full,
                           input int hrs);
    logic [7:0] b;
    logic [7:0] exp [9];
    exp = '{k, k ^ 8'h40, 8'(hrs), 8'(hrs >> 8), k ^ 8'h80, 8'h3C, ~k, 8'h5A, k};
    if (!full) exp = '{default: 8'h00};
    for (int i = 0; i < 9; i++) begin
      logByte(10'(2 + 24 * slot + i), b);
      check("descriptor byte", b, exp[i]);
    end
  endtask : checkDesc
  // A wrong cylinder key aborts even with monitoring on
  task automatic testBadCmd();
    logic [7:0] st;
    host.smartCmd(`F_ENA, 8'h00, 8'h00, 16'hC24E);
    @(posedge clk);
    host.rd(`R_STAT, st);
    check("bad cylinder err", st[2], 1'h1);
    check("monitor kept", monitorEn, 1'h1);
  endtask : testBadCmd
  task automatic testLog();
    logic [7:0] b;
    logic [7:0] sum;
    logByte(10'h000, b);
    check("revision low", b, 8'h01);
    logByte(10'h001, b);
    check("revision high", b, 8'h00);
    logByte(10'h1FC, b);
    check("index empty", b, 8'h00);
    for (int k = 1; k <= 22; k++) begin
      selfTest(8'(k));
      logByte(10'h1FC, b);
      check("index", b, k == 22 ? 8'h01 : 8'(k));
      if (k == 1) begin
        checkDesc(0, 8'h01, 1'h1, hrsAt[1]);
        checkDesc(1, 8'h00, 1'h0, 0);
      end
    end
    checkDesc(0, 8'h16, 1'h1, hrsAt[22]);
    checkDesc(1, 8'h02, 1'h1, hrsAt[2]);
    checkDesc(20, 8'h15, 1'h1, hrsAt[21]);
    sum = 8'h00;
    host.wr(`R_LADR, 10'h000);
    for (int i = 0; i < 512; i++) begin
      host.rd(`R_LDAT, b);
      sum += b;
    end
    check("sector sum", sum, 8'h00);
  endtask : testLog
  task automatic testWriteLog();
    logic [7:0] b;
    host.smartCmd(`F_WLOG, 8'h01, 8'h80, `CYL_KEY);
    @(posedge clk);
    host.rd(`R_STAT, b);
    check("data phase", b[3], 1'h1);
    for (int i = 0; i < 512; i++) begin
      host.wr(`R_LDAT, {2'h0, 8'(i) ^ 8'hA5});
    end
    host.rd(`R_SCNT, b);
    check("count after log write", b, 8'h00);
    host.rd(`R_STAT, b);
    check("data phase over", b[3], 1'h0);
  endtask : testWriteLog
  task automatic testOffline();
    logic [7:0] st;
    int n;
    cmd(`F_AUTO, `SC_ON, st);
    check("auto enabled", st[5], 1'h1);
    countPulses(48 * HOUR_N, 1'h0, n);
    check("runs in 48 hours", n, 2);
    cmd(`F_AUTO, `SC_OFF, st);
    check("auto disabled", st[5], 1'h0);
    countPulses(25 * HOUR_N, 1'h0, n);
    check("runs after disable", n, 0);
    pwrEvent <= 1'h1;
    countPulses(8, 1'h1, n);
    check("power event save", n, 1);
    pwrEvent <= 1'h0;
  endtask : testOffline
  initial begin
    logic [7:0] st;
    doReset(1'h0);
    testAbortOff();
    testOnOff(`F_ENA, 1'h1);
    testOnOff(`F_ENA, 1'h1);
    testStatus();
    testBadCmd();
    testLog();
    testWriteLog();
    testOffline();
    testOnOff(`F_DIS, 1'h0);
    cmd(`F_DIS, 8'h00, st);
    check("repeat disable err", st[2], 1'h1);
    doReset(1'h1);
    check("monitor restored", monitorEn, 1'h1);
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule : smart_selftest_log_commands_tb_top
`default_nettype wire
